// ===== verilog/srpc_top.sv
// Our own choice: register access over APB.
`timescale 1ns/10ps
module srpc_top
  import srpc_pkg::*;
#(
  parameter int          DELAY_W       = 16,
  parameter logic        HAS_BOD_SLEEP = 1'b1,
  parameter int          WD_CNT_W      = 20
)(
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                reset_i,
  // APB slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [11:0]         paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // Reset sources and fuses
  input  wire logic                por_low_i,
  input  wire logic                ext_reset_n_i,
  input  wire logic                reset_pin_en_i,
  input  wire logic                bod_low_i,
  input  wire logic                bod_fuse_en_i,
  input  wire logic [DELAY_W-1:0]  startup_timeout_i,
  input  wire logic                wd_always_on_fuse_i,
  input  wire logic                wd_tick_i,
  input  wire logic                wd_restart_i,
  // Peripheral access from the core
  input  wire logic [3:0]          periph_access_i,
  // Outputs
  output logic                     core_reset_o,
  output logic                     port_reset_o,
  output logic [3:0]               periph_clk_en_o,
  output logic [3:0]               periph_access_ok_o,
  output logic                     bandgap_en_o,
  output logic [3:0]               sleep_mode_o,
  output logic                     bod_sleep_off_o,
  output logic                     wd_irq_o
);

  // Clocked state
  srpc_rst_t            rst_state_r;
  logic [DELAY_W-1:0]   delay_cnt_r;
  logic [3:0]           gate_r;
  logic [1:0]           sleep_sel_r;
  logic                 bsu_arm_r;
  logic [2:0]           bsu_win_r;
  logic [1:0]           bsd_dly_r;
  logic [1:0]           bsd_on_r;
  logic                 bsd_pend_r;
  logic                 bsd_act_r;
  logic                 bg_sel_r;
  logic                 conv_en_r;
  logic                 wd_en_r;
  logic                 wd_ie_r;
  logic                 wd_if_r;
  logic [3:0]           wd_per_r;
  logic                 wd_unlk_r;
  logic [2:0]           wd_unlk_cnt_r;
  logic [WD_CNT_W-1:0]  wd_cnt_r;
  logic                 wd_pulse_r;

  // Bus decode
  logic                 wr_en;
  logic                 rd_en;
  logic                 src_active;
  logic                 wd_expire;
  logic                 wd_run;
  logic [WD_CNT_W-1:0]  wd_limit;

  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && penable_i && !pwrite_i;

  // Watchdog timeout in ticks for each of the ten periods
  function automatic logic [WD_CNT_W-1:0] wd_period(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > 4'h9) ? 4'h9 : sel;
    wd_period = WD_CNT_W'(2048) << s;
  endfunction

  assign wd_limit  = wd_period(wd_per_r);
  assign wd_run    = wd_en_r || wd_ie_r || wd_always_on_fuse_i;
  assign wd_expire = wd_run && wd_tick_i && (wd_cnt_r >= wd_limit - 1'b1);

  // Combined reset sources: asynchronous inputs plus the registered watchdog pulse
  assign src_active = por_low_i
                   || (reset_pin_en_i && !ext_reset_n_i)
                   || (bod_fuse_en_i && bod_low_i)
                   || wd_pulse_r;

  // Reset stretch sequencer
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      rst_state_r <= SRPC_RS_HOLD;
      delay_cnt_r <= '0;
    end
    else if (src_active)
    begin
      rst_state_r <= SRPC_RS_HOLD;
      delay_cnt_r <= '0;
    end
    else
    begin
      case (rst_state_r)
        SRPC_RS_HOLD:
        begin
          rst_state_r <= SRPC_RS_STRETCH;
          delay_cnt_r <= '0;
        end
        SRPC_RS_STRETCH:
        begin
          if (delay_cnt_r >= startup_timeout_i)
            rst_state_r <= SRPC_RS_RUN;
          else
            delay_cnt_r <= delay_cnt_r + 1'b1;
        end
        SRPC_RS_RUN:
          rst_state_r <= SRPC_RS_RUN;
        default:
          rst_state_r <= SRPC_RS_HOLD;
      endcase
    end
  end

  // Internal reset level and registered port reset
  logic chip_rst;
  assign chip_rst = reset_i || (rst_state_r != SRPC_RS_RUN);

  always_ff @(posedge clock_i)
  begin
    core_reset_o <= reset_i || src_active || (rst_state_r != SRPC_RS_RUN);
    port_reset_o <= reset_i || src_active;
  end

  // Gate register
  always_ff @(posedge clock_i)
  begin
    if (chip_rst)
      gate_r <= SRPC_GATE_RST;
    else if (wr_en && paddr_i == SRPC_GATE_ADDR)
      gate_r <= pwdata_i[3:0];
  end

  // Sleep selector and brownout sleep unlock sequence
  logic pwr_wr;
  assign pwr_wr = wr_en && paddr_i == SRPC_PWR_ADDR;

  always_ff @(posedge clock_i)
  begin
    if (chip_rst)
    begin
      sleep_sel_r <= 2'h0;
      bsu_arm_r   <= 1'b0;
      bsu_win_r   <= 3'h0;
      bsd_pend_r  <= 1'b0;
      bsd_dly_r   <= 2'h0;
      bsd_act_r   <= 1'b0;
      bsd_on_r    <= 2'h0;
    end
    else
    begin
      if (pwr_wr)
        sleep_sel_r <= pwdata_i[SRPC_PWR_SMHI:SRPC_PWR_SMLO];
      if (pwr_wr && HAS_BOD_SLEEP && pwdata_i[SRPC_PWR_BSU]
          && pwdata_i[SRPC_PWR_BSD])
      begin
        bsu_arm_r <= 1'b1;
        bsu_win_r <= SRPC_UNLOCK_CYC;
      end
      else if (pwr_wr && bsu_arm_r && pwdata_i[SRPC_PWR_BSD])
      begin
        bsu_arm_r  <= 1'b0;
        bsd_pend_r <= 1'b1;
        bsd_dly_r  <= SRPC_BSD_DLY_CYC;
      end
      else if (bsu_win_r != 3'h0)
      begin
        bsu_win_r <= bsu_win_r - 3'h1;
        if (bsu_win_r == 3'h1)
          bsu_arm_r <= 1'b0;
      end
      if (bsd_pend_r)
      begin
        if (bsd_dly_r == 2'h1)
        begin
          bsd_pend_r <= 1'b0;
          bsd_act_r  <= 1'b1;
          bsd_on_r   <= SRPC_BSD_ON_CYC;
        end
        else
          bsd_dly_r <= bsd_dly_r - 2'h1;
      end
      else if (bsd_act_r)
      begin
        if (bsd_on_r == 2'h1)
          bsd_act_r <= 1'b0;
        else
          bsd_on_r <= bsd_on_r - 2'h1;
      end
    end
  end

  // Config register: comparator bandgap select, converter enable
  always_ff @(posedge clock_i)
  begin
    if (chip_rst)
    begin
      bg_sel_r  <= 1'b0;
      conv_en_r <= 1'b0;
    end
    else if (wr_en && paddr_i == SRPC_CFG_ADDR)
    begin
      bg_sel_r  <= pwdata_i[SRPC_CFG_BG];
      conv_en_r <= pwdata_i[SRPC_CFG_CONV];
    end
  end

  // Watchdog control with timed change sequences
  logic wd_wr;
  logic [3:0] wd_per_new;
  assign wd_wr = wr_en && paddr_i == SRPC_WDOG_ADDR;
  assign wd_per_new = {pwdata_i[SRPC_WD_PHI], pwdata_i[2:0]};

  always_ff @(posedge clock_i)
  begin
    if (chip_rst)
    begin
      wd_en_r       <= 1'b0;
      wd_ie_r       <= 1'b0;
      wd_per_r      <= 4'h0;
      wd_unlk_r     <= 1'b0;
      wd_unlk_cnt_r <= 3'h0;
    end
    else
    begin
      if (wd_wr && pwdata_i[SRPC_WD_UNLK] && pwdata_i[SRPC_WD_EN])
      begin
        wd_unlk_r     <= 1'b1;
        wd_unlk_cnt_r <= SRPC_UNLOCK_CYC;
        wd_en_r       <= 1'b1;
        wd_ie_r       <= pwdata_i[SRPC_WD_IE];
      end
      else
      begin
        if (wd_unlk_cnt_r != 3'h0)
        begin
          wd_unlk_cnt_r <= wd_unlk_cnt_r - 3'h1;
          if (wd_unlk_cnt_r == 3'h1)
            wd_unlk_r <= 1'b0;
        end
        if (wd_wr)
        begin
          wd_ie_r <= pwdata_i[SRPC_WD_IE];
          if (pwdata_i[SRPC_WD_EN])
            wd_en_r <= 1'b1;
          else if (wd_unlk_r && !wd_always_on_fuse_i)
            wd_en_r <= 1'b0;
          if (wd_unlk_r || !wd_always_on_fuse_i)
            wd_per_r <= wd_per_new;
        end
        else if (wd_expire && (wd_en_r || wd_always_on_fuse_i) && wd_ie_r)
          wd_ie_r <= 1'b0;
      end
    end
  end

  // Watchdog counter, pulse and interrupt flag
  always_ff @(posedge clock_i)
  begin
    if (chip_rst)
      wd_cnt_r <= '0;
    else if (wd_restart_i || !(wd_run || wd_always_on_fuse_i))
      wd_cnt_r <= '0;
    else if (wd_expire)
      wd_cnt_r <= '0;
    else if (wd_tick_i)
      wd_cnt_r <= wd_cnt_r + 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      wd_pulse_r <= 1'b0;
    else
      wd_pulse_r <= wd_expire && (wd_en_r || wd_always_on_fuse_i)
                    && !wd_ie_r;
  end

  always_ff @(posedge clock_i)
  begin
    if (chip_rst)
      wd_if_r <= 1'b0;
    else if (wd_expire && wd_ie_r)
      wd_if_r <= 1'b1;
    else if (wd_wr && pwdata_i[SRPC_WD_IF])
      wd_if_r <= 1'b0;
  end

  // Peripheral outputs, bandgap and sleep mode
  always_ff @(posedge clock_i)
  begin
    periph_clk_en_o    <= ~gate_r;
    periph_access_ok_o <= periph_access_i & ~gate_r;
    bandgap_en_o       <= bod_fuse_en_i || bg_sel_r
                          || (conv_en_r && !gate_r[SRPC_GATE_CONV]);
    bod_sleep_off_o    <= bsd_act_r;
    wd_irq_o           <= wd_if_r;
    case (sleep_sel_r)
      2'h0:    sleep_mode_o <= SRPC_SLP_IDLE;
      2'h1:    sleep_mode_o <= SRPC_SLP_NOISE;
      2'h2:    sleep_mode_o <= SRPC_SLP_PWRDOWN;
      default: sleep_mode_o <= SRPC_SLP_STANDBY;
    endcase
  end

  // APB read data and response, zero wait states
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      prdata_o  <= 32'h0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
      if (psel_i && !penable_i)
      begin
        if (paddr_i == SRPC_GATE_ADDR)
          prdata_o <= {28'h0, gate_r};
        else if (paddr_i == SRPC_PWR_ADDR)
          prdata_o <= {24'h0, bsd_act_r, 2'h0, sleep_sel_r,
                       HAS_BOD_SLEEP & bsu_arm_r, 2'h0};
        else if (paddr_i == SRPC_WDOG_ADDR)
          prdata_o <= {24'h0, wd_if_r, wd_ie_r, wd_per_r[3], wd_unlk_r,
                       wd_en_r | wd_always_on_fuse_i, wd_per_r[2:0]};
        else if (paddr_i == SRPC_STAT_ADDR)
          prdata_o <= {29'h0, rst_state_r};
        else if (paddr_i == SRPC_CFG_ADDR)
          prdata_o <= {30'h0, conv_en_r, bg_sel_r};
        else
          pslverr_o <= 1'b1;
      end
    end
  end

endmodule

// ===== include/srpc_pkg.sv
package srpc_pkg;
  // Register byte addresses
  localparam logic [11:0] SRPC_GATE_ADDR   = 12'h000;
  localparam logic [11:0] SRPC_PWR_ADDR    = 12'h004;
  localparam logic [11:0] SRPC_WDOG_ADDR   = 12'h008;
  localparam logic [11:0] SRPC_STAT_ADDR   = 12'h00c;
  localparam logic [11:0] SRPC_CFG_ADDR    = 12'h010;
  // Gate register fields
  localparam int SRPC_GATE_TIM1 = 3;
  localparam int SRPC_GATE_TIM0 = 2;
  localparam int SRPC_GATE_SER  = 1;
  localparam int SRPC_GATE_CONV = 0;
  localparam logic [3:0] SRPC_GATE_RST = 4'h0;
  // Power control fields
  localparam int SRPC_PWR_BSD   = 7;
  localparam int SRPC_PWR_SMHI  = 4;
  localparam int SRPC_PWR_SMLO  = 3;
  localparam int SRPC_PWR_BSU   = 2;
  // Watchdog control fields
  localparam int SRPC_WD_PHI    = 5;
  localparam int SRPC_WD_UNLK   = 4;
  localparam int SRPC_WD_EN     = 3;
  localparam int SRPC_WD_IE     = 6;
  localparam int SRPC_WD_IF     = 7;
  // Config register fields
  localparam int SRPC_CFG_BG    = 0;
  localparam int SRPC_CFG_CONV  = 1;
  localparam int SRPC_CFG_RESTART = 2;
  // Timing counts in system clock cycles, and the number of watchdog periods
  localparam logic [2:0] SRPC_UNLOCK_CYC  = 3'h4;
  localparam logic [1:0] SRPC_BSD_DLY_CYC = 2'h3;
  localparam logic [1:0] SRPC_BSD_ON_CYC  = 2'h3;
  localparam int SRPC_WD_PERIODS = 10;
  // Sleep modes
  typedef enum logic [3:0] {
    SRPC_SLP_IDLE    = 4'b0001,
    SRPC_SLP_NOISE   = 4'b0010,
    SRPC_SLP_PWRDOWN = 4'b0100,
    SRPC_SLP_STANDBY = 4'b1000
  } srpc_sleep_t;
  // Reset sequencer states
  typedef enum logic [2:0] {
    SRPC_RS_HOLD    = 3'b001,
    SRPC_RS_STRETCH = 3'b010,
    SRPC_RS_RUN     = 3'b100
  } srpc_rst_t;
endpackage

// ===== tb/srpc_sva.sv
`timescale 1ns/10ps
// Port level checks of the reset sequencer and register side
module srpc_sva #(
  parameter int DELAY_W = 16
)(
  input wire logic               clock_i,
  input wire logic               reset_i,
  input wire logic               psel_i,
  input wire logic               penable_i,
  input wire logic               pready_o,
  input wire logic               pslverr_o,
  input wire logic               por_low_i,
  input wire logic               ext_reset_n_i,
  input wire logic               reset_pin_en_i,
  input wire logic               bod_low_i,
  input wire logic               bod_fuse_en_i,
  input wire logic [DELAY_W-1:0] startup_timeout_i,
  input wire logic [3:0]         periph_access_i,
  input wire logic               core_reset_o,
  input wire logic               port_reset_o,
  input wire logic [3:0]         periph_access_ok_o,
  input wire logic               bandgap_en_o,
  input wire logic [3:0]         sleep_mode_o,
  input wire logic               bod_sleep_off_o,
  input wire logic               wd_irq_o
);
  logic [DELAY_W:0] run_r;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // Stretch cycles seen since the last source went quiet
  always_ff @(posedge clock_i)
    if (reset_i || port_reset_o) run_r <= '0;
    else if (core_reset_o) run_r <= run_r + 1'b1;
  a_ready_access: assert property (psel_i && penable_i |-> pready_o)
    else $error("no pready in access phase");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready held too long");
  a_err_ready: assert property (pslverr_o |-> pready_o && psel_i)
    else $error("pslverr outside an answer");
  a_port_source: assert property (por_low_i || (bod_fuse_en_i && bod_low_i) ||
    (reset_pin_en_i && !ext_reset_n_i) |=> port_reset_o)
    else $error("port reset missed a source");
  a_core_hold: assert property (port_reset_o |=> core_reset_o)
    else $error("core left reset under a source");
  a_stretch_len: assert property ($fell(core_reset_o) |->
    run_r >= {1'b0, startup_timeout_i})
    else $error("reset stretch too short");
  a_sleep_onehot: assert property ($onehot(sleep_mode_o))
    else $error("sleep mode not one-hot");
  a_brownout_sleep_disable_width: assert property ($rose(bod_sleep_off_o) |->
    bod_sleep_off_o [*3] ##1 !bod_sleep_off_o)
    else $error("brownout sleep disable width wrong");
  a_bandgap_fuse: assert property (bod_fuse_en_i |=> bandgap_en_o)
    else $error("bandgap off with detector fused");
  a_access_req: assert property (
    (periph_access_ok_o & ~$past(periph_access_i)) == 4'h0)
    else $error("access granted without request");
  c_release: cover property ($fell(core_reset_o));
  c_brownout_sleep_disable: cover property ($rose(bod_sleep_off_o));
  c_wd_irq: cover property ($rose(wd_irq_o));
  c_err: cover property (pslverr_o);
endmodule
bind srpc_top srpc_sva #(.DELAY_W(DELAY_W)) u_srpc_sva (
  .clock_i(clock_i), .reset_i(reset_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .por_low_i(por_low_i), .ext_reset_n_i(ext_reset_n_i),
  .reset_pin_en_i(reset_pin_en_i), .bod_low_i(bod_low_i),
  .bod_fuse_en_i(bod_fuse_en_i), .startup_timeout_i(startup_timeout_i),
  .periph_access_i(periph_access_i), .core_reset_o(core_reset_o),
  .port_reset_o(port_reset_o), .periph_access_ok_o(periph_access_ok_o),
  .bandgap_en_o(bandgap_en_o), .sleep_mode_o(sleep_mode_o),
  .bod_sleep_off_o(bod_sleep_off_o), .wd_irq_o(wd_irq_o));

// ===== tb/srpc_periph.sv
`timescale 1ns/10ps
// Gated timers and the watchdog oscillator on the far side
module srpc_periph (
  // Clock and gates
  input  wire logic        clock_i,
  input  wire logic [3:0]  clk_en_i,
  // Observed state
  output logic [7:0]       tim0_cnt_o,
  output logic [15:0]      tim1_cnt_o,
  output logic             wd_tick_o
);
  initial
  begin
    tim0_cnt_o = 8'h00;
    tim1_cnt_o = 16'h0000;
    wd_tick_o = 1'b0;
  end
  // Timers advance only while clocked, so a gate freezes them
  always @(posedge clock_i)
  begin
    if (clk_en_i[2]) tim0_cnt_o <= tim0_cnt_o + 8'h01;
    if (clk_en_i[3]) tim1_cnt_o <= tim1_cnt_o + 16'h0001;
    wd_tick_o <= ~wd_tick_o;
  end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/10ps
// Self-checking bench for the reset and power control block
module testbench;
  import srpc_pkg::*;
  logic clock_i, reset_i, psel, penable, pwrite, pready, pslverr, er;
  logic por_low, ext_n, pin_en, bod_low, bod_fuse, wd_aon, wd_tick, wd_rst;
  logic core_rst, port_rst, bg, brownout_sleep_disable, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] tmo;
  logic [3:0]  acc, clk_en, acc_ok, slp;
  logic [7:0]  tim0, s;
  int errors, n_checks, cyc, gone, k;
  srpc_top u_srpc_top (.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .por_low_i(por_low), .ext_reset_n_i(ext_n),
    .reset_pin_en_i(pin_en), .bod_low_i(bod_low), .bod_fuse_en_i(bod_fuse),
    .startup_timeout_i(tmo), .wd_always_on_fuse_i(wd_aon),
    .wd_tick_i(wd_tick), .wd_restart_i(wd_rst), .periph_access_i(acc),
    .core_reset_o(core_rst), .port_reset_o(port_rst),
    .periph_clk_en_o(clk_en), .periph_access_ok_o(acc_ok),
    .bandgap_en_o(bg), .sleep_mode_o(slp), .bod_sleep_off_o(brownout_sleep_disable),
    .wd_irq_o(irq));
  srpc_periph u_srpc_periph (.clock_i(clock_i), .clk_en_i(clk_en),
    .tim0_cnt_o(tim0), .tim1_cnt_o(), .wd_tick_o(wd_tick));
  // Clock and hang guard
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      close_out;
    end
  end
  task close_out;
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error taken at the pready edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    while (pready !== 1'b1) @(posedge clock_i);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wait for the core to leave reset, counting the cycles
  task till(input int lim);
    gone = 0;
    while (core_rst !== 1'b0 && gone < lim)
    begin
      @(posedge clock_i);
      gone++;
    end
  endtask
  task t_regs;
    apb(0, SRPC_GATE_ADDR, 0);
    chk(rd, 32'h0);
    apb(1, SRPC_GATE_ADDR, 32'hff);
    apb(0, SRPC_GATE_ADDR, 0);
    chk(rd, 32'h0f);
    chk({28'h0, clk_en}, 32'h0);
    apb(0, 12'h100, 0);
    chk({31'h0, er}, 32'h1);
    apb(1, SRPC_GATE_ADDR, 0);
  endtask
  task t_freeze;
    acc <= 4'hf;
    apb(1, SRPC_GATE_ADDR, 32'h04);
    repeat (2) @(posedge clock_i);
    s = tim0;
    repeat (5) @(posedge clock_i);
    chk({24'h0, tim0}, {24'h0, s});
    chk({28'h0, acc_ok}, 32'hb);
    apb(1, SRPC_GATE_ADDR, 0);
    repeat (3) @(posedge clock_i);
    chk({31'h0, tim0 != s}, 32'h1);
    acc <= 4'h0;
  endtask
  task t_sleep;
    for (int m = 0; m < 4; m++)
    begin
      apb(1, SRPC_PWR_ADDR, m << 3);
      repeat (2) @(posedge clock_i);
      chk({28'h0, slp}, 32'h1 << m);
    end
  endtask
  task t_brownout_sleep_disable(input logic arm);
    if (arm) apb(1, SRPC_PWR_ADDR, 32'h84);
    apb(1, SRPC_PWR_ADDR, 32'h80);
    k = 0;
    repeat (12)
    begin
      @(posedge clock_i);
      k += (brownout_sleep_disable === 1'b1);
    end
    chk(k, arm ? 3 : 0);
  endtask
  task t_bg;
    bod_fuse <= 1'b0;
    for (int m = 0; m < 3; m++)
    begin
      apb(1, SRPC_CFG_ADDR, m);
      repeat (2) @(posedge clock_i);
      chk({31'h0, bg}, m != 0);
    end
    apb(1, SRPC_CFG_ADDR, 0);
    bod_fuse <= 1'b1;
  endtask
  // Sources: 0 power-on, 1 pin, 2 brown-out, 3 power-on with re-entry
  task t_src(input int w);
    @(posedge clock_i);
    por_low <= (w == 0 || w == 3);
    ext_n <= (w != 1);
    bod_low <= (w == 2);
    repeat (3) @(posedge clock_i);
    chk({30'h0, port_rst, core_rst}, 32'h3);
    por_low <= 1'b0;
    ext_n <= 1'b1;
    bod_low <= 1'b0;
    if (w == 3)
    begin
      repeat (3) @(posedge clock_i);
      por_low <= 1'b1;
      @(posedge clock_i);
      por_low <= 1'b0;
    end
    till(100);
    chk({31'h0, gone >= 5 && gone < 100}, 32'h1);
  endtask
  task t_wd;
    apb(1, SRPC_WDOG_ADDR, 32'h08);
    repeat (3900) @(posedge clock_i);
    chk({31'h0, core_rst}, 32'h0);
    k = 0;
    while (core_rst !== 1'b1 && k < 600)
    begin
      @(posedge clock_i);
      k++;
    end
    chk({31'h0, core_rst}, 32'h1);
    till(100);
    apb(1, SRPC_WDOG_ADDR, 32'h40);
    k = 0;
    while (irq !== 1'b1 && k < 4500)
    begin
      @(posedge clock_i);
      k++;
    end
    chk({30'h0, irq, core_rst}, 32'h2);
    apb(1, SRPC_WDOG_ADDR, 32'hc0);
    repeat (3000) @(posedge clock_i);
    wd_rst <= 1'b1;
    @(posedge clock_i);
    wd_rst <= 1'b0;
    repeat (1200) @(posedge clock_i);
    chk({31'h0, irq}, 32'h0);
  endtask
  // Watchdog safety levels and the change unlock window
  task t_lvl;
    apb(1, SRPC_WDOG_ADDR, 32'h08);
    apb(1, SRPC_WDOG_ADDR, 32'h00);
    apb(0, SRPC_WDOG_ADDR, 0);
    chk(rd, 32'h08);
    apb(1, SRPC_WDOG_ADDR, 32'h18);
    repeat (4) @(posedge clock_i);
    apb(1, SRPC_WDOG_ADDR, 32'h00);
    apb(0, SRPC_WDOG_ADDR, 0);
    chk(rd, 32'h08);
    apb(1, SRPC_WDOG_ADDR, 32'h18);
    apb(1, SRPC_WDOG_ADDR, 32'h00);
    apb(0, SRPC_WDOG_ADDR, 0);
    chk(rd, 32'h00);
    wd_aon <= 1'b1;
    apb(1, SRPC_WDOG_ADDR, 32'h21);
    apb(0, SRPC_WDOG_ADDR, 0);
    chk(rd, 32'h08);
    apb(1, SRPC_WDOG_ADDR, 32'h18);
    apb(1, SRPC_WDOG_ADDR, 32'h21);
    apb(0, SRPC_WDOG_ADDR, 0);
    chk(rd, 32'h29);
  endtask
  // Main sequence
  initial
  begin
    {reset_i, ext_n, pin_en, bod_fuse} = 4'hf;
    {psel, penable, pwrite, por_low, bod_low, wd_aon, wd_rst} = 7'h0;
    {paddr, pwdata, acc, errors, n_checks, cyc} = '0;
    tmo = 16'h0004;
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    till(200);
    t_regs;
    t_freeze;
    t_sleep;
    t_brownout_sleep_disable(1'b1);
    t_brownout_sleep_disable(1'b0);
    t_bg;
    for (int w = 0; w < 4; w++) t_src(w);
    t_wd;
    t_lvl;
    close_out;
  end
endmodule
